/* File: rtl/wire_mode_pkg.sv */
package wire_mode_pkg;
	// Wire mode encodings
	localparam logic [1:0] MODE_OFF     = 2'h0;
	localparam logic [1:0] MODE_THREE   = 2'h1;
	localparam logic [1:0] MODE_TWO     = 2'h2;
	localparam logic [1:0] MODE_TWO_OVF = 2'h3;
	localparam logic [1:0] MODE_RESET   = 2'h0;
	// Data path geometry
	localparam int         DATA_W       = 8;
	localparam int         DATA_MSB     = 7;
	localparam int         CNT_W        = 4;
	localparam logic [3:0] CNT_MAX      = 4'hF;
	localparam logic [3:0] CNT_RESET    = 4'h0;
	localparam int         FIFO_DEPTH   = 16;
	localparam logic [7:0] SHIFT_RESET  = 8'h00;

	// Port latch and direction bit of one pin
	typedef struct packed {
		logic latch;
		logic dir;
	} port_cfg_s;

	// Drive of one pin
	typedef struct packed {
		logic out;
		logic oe;
		logic pull_up;
	} pin_drive_s;

	localparam pin_drive_s PIN_RESET = 3'h0;

	// Transfer state, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} xfer_e;
endpackage : wire_mode_pkg

/* File: rtl/byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] FULL = (PTR_W+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0]   cnt_reg;
	logic [PTR_W:0]   cnt_next;
	logic             push;
	logic             pop;

	// Output stage is a register, so a read costs one cycle
	assign push     = in_valid && in_ready && ce;
	assign pop      = ce && (cnt_reg != '0) && (!out_valid || out_ready);
	assign cnt_next = cnt_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

	// Storage array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
			in_ready   <= 1'h0;
		end else if (ce) begin
			wr_ptr_reg <= wr_ptr_reg + PTR_W'(push);
			rd_ptr_reg <= rd_ptr_reg + PTR_W'(pop);
			cnt_reg    <= cnt_next;
			in_ready   <= cnt_next != FULL; // Registered from the next count, so full shows in the same cycle it is reached
		end
	end

	// Registered read data
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_valid <= 1'h0;
			out_data  <= '0;
		end else if (ce) begin
			if (pop) begin
				out_valid <= 1'h1;
				out_data  <= mem[rd_ptr_reg];
			end else if (out_ready) begin
				out_valid <= 1'h0;
			end
		end
	end
endmodule : byte_fifo

/* File: rtl/serial_wire_mode_output_control.sv */
// Overview of operation
// RL1: Wire mode alters outputs only; inputs always clock shifter and counter.
// RL2: Mode zero: serial outputs, clock hold and start detection off; port pins.
// RL3: Three-wire: serial data replaces data pin latch; direction bit still gates drive.
// RL4: Three-wire: data pin as input takes pull-up from its port latch.
// RL5: Three-wire: data-in and clock pins keep normal port behaviour.
// RL6: Three-wire master software toggles clock latch with pin set as output.
// RL7: Modes two and three: data and clock pins are open-drain bidirectional.
// RL8: Two-wire drivers act only while their direction bits are set.
// RL9: Enabled data driver pulls low if shifter output or latch is zero.
// RL10: Enabled clock driver pulls low if latch zero or start hold active.
// RL11: Two-wire start condition holds clock low until start flag cleared.
// RL12: Clearing the start flag releases the start clock hold.
// RL13: Two-wire mode disables pull-ups on data and clock pins.
// RL14: Mode three also holds clock low after counter overflow until flag cleared.
// RL15: Data pin driven from shifter bit seven through output latch.
// RL16: Start flag clears only on a written one; zero leaves it.
// RL17: Overflow flag sets when the counter wraps from fifteen to zero.
// RL18: Reset leaves wire mode zero, pins as plain port pins.
`timescale 1ns/1ps
module serial_wire_mode_output_control
	import wire_mode_pkg::*;
(
	// Clock, reset and enable
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         ce,
	// Configuration
	input  wire logic [1:0]   wire_mode_select,
	input  wire port_cfg_s    do_cfg,
	input  wire port_cfg_s    sda_cfg,
	input  wire port_cfg_s    scl_cfg,
	// Flag clear strobes, write-one
	input  wire logic         start_flag_clear,
	input  wire logic         ovf_flag_clear,
	// Transmit byte stream
	input  wire logic         tx_valid,
	input  wire logic [7:0]   tx_data,
	output logic              tx_ready,
	// Received bytes and status
	output logic [7:0]        rx_data_reg,
	output logic              rx_strobe_reg,
	output logic              start_detect_flag,
	output logic              count_overflow_flag,
	output logic [3:0]        count_reg,
	// Pins
	input  wire logic         serial_in_pin,
	input  wire logic         serial_clock_pin,
	output pin_drive_s        do_pin_reg,
	output pin_drive_s        sda_pin_reg,
	output pin_drive_s        scl_pin_reg
);
	logic             sda_s1_reg;
	logic             sda_s2_reg;
	logic             sda_d_reg;
	logic             scl_s1_reg;
	logic             scl_s2_reg;
	logic             scl_d_reg;
	logic             scl_edge;
	logic             scl_rise;
	logic             start_cond;
	logic             two_wire;
	logic             wrap;
	logic             hold;
	logic [7:0]       shift_reg;
	logic [7:0]       shift_in;
	logic             out_latch_reg;
	xfer_e            state_reg;
	logic             fifo_valid;
	logic [7:0]       fifo_data;
	logic             load;
	pin_drive_s       do_pin_next;
	pin_drive_s       sda_pin_next;
	pin_drive_s       scl_pin_next;

	// Plain port drive of one pin
	function automatic pin_drive_s port_drive(input port_cfg_s cfg);
		pin_drive_s d;
		d.out     = cfg.latch;
		d.oe      = cfg.dir;
		d.pull_up = !cfg.dir && cfg.latch; // RL4
		return d;
	endfunction : port_drive

	// Transmit bytes wait here; the writer stalls only once all 16 entries are full
	byte_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk      (clk),
		.nrst     (nrst),
		.ce       (ce),
		.in_valid (tx_valid),
		.in_data  (tx_data),
		.in_ready (tx_ready),
		.out_valid(fifo_valid),
		.out_data (fifo_data),
		.out_ready(load)
	);

	// Pin synchronisers; the second stage and its delayed copy are looked at
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sda_s1_reg <= 1'h1;
			sda_s2_reg <= 1'h1;
			sda_d_reg  <= 1'h1;
			scl_s1_reg <= 1'h1;
			scl_s2_reg <= 1'h1;
			scl_d_reg  <= 1'h1;
		end else if (ce) begin
			sda_s1_reg <= serial_in_pin;
			sda_s2_reg <= sda_s1_reg;
			sda_d_reg  <= sda_s2_reg;
			scl_s1_reg <= serial_clock_pin;
			scl_s2_reg <= scl_s1_reg;
			scl_d_reg  <= scl_s2_reg;
		end
	end

	// Edge and start detection; edges ignore the mode, start detection is two-wire only
	assign two_wire   = wire_mode_select[1];
	assign scl_edge   = scl_s2_reg ^ scl_d_reg; // RL1
	assign scl_rise   = scl_s2_reg && !scl_d_reg;
	assign start_cond = two_wire && scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg; // RL2
	assign wrap       = scl_edge && (count_reg == CNT_MAX); // RL17
	assign load       = (state_reg == ST_IDLE) && fifo_valid && ce;
	assign shift_in   = {shift_reg[DATA_MSB-1:0], sda_s2_reg};

	// Counter steps on both clock edges in every mode
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= CNT_RESET;
		end else if (ce && scl_edge) begin
			count_reg <= count_reg + 4'h1; // RL1
		end
	end

	// Shifter: sample on rising edge, load from queue when idle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shift_reg <= SHIFT_RESET;
		end else if (ce) begin
			if (load) begin
				shift_reg <= fifo_data;
			end else if (scl_rise) begin
				shift_reg <= shift_in; // RL1
			end
		end
	end

	// Latch open while clock is low, so output moves opposite the sample edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_latch_reg <= 1'h1;
		end else if (ce && !scl_s2_reg) begin
			out_latch_reg <= shift_reg[DATA_MSB]; // RL15
		end
	end

	// Transfer state; a wrap ends the byte and hands it out
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg     <= ST_IDLE;
			rx_data_reg   <= SHIFT_RESET;
			rx_strobe_reg <= 1'h0;
		end else if (ce) begin
			rx_strobe_reg <= wrap;
			if (wrap) begin
				// Last bit can arrive on the very edge that wraps the counter
				rx_data_reg <= scl_rise ? shift_in : shift_reg;
			end
			unique case (state_reg)
				ST_IDLE: begin
					if (load) begin
						state_reg <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					if (wrap) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start_detect_flag   <= 1'h0;
			count_overflow_flag <= 1'h0;
		end else if (ce) begin
			if (start_cond) begin
				start_detect_flag <= 1'h1; // RL11
			end else if (start_flag_clear) begin
				start_detect_flag <= 1'h0; // RL16
			end
			if (wrap) begin
				count_overflow_flag <= 1'h1; // RL17
			end else if (ovf_flag_clear) begin
				count_overflow_flag <= 1'h0;
			end
		end
	end

	// Clock hold sources in two-wire modes
	assign hold = two_wire && (start_detect_flag // RL12
		|| (wire_mode_select == MODE_TWO_OVF && count_overflow_flag)); // RL14

	// Pin drive selection by wire mode
	always_comb begin
		do_pin_next  = port_drive(do_cfg);
		sda_pin_next = port_drive(sda_cfg); // RL5
		scl_pin_next = port_drive(scl_cfg);
		unique case (wire_mode_select)
			MODE_OFF: begin
				do_pin_next = port_drive(do_cfg); // RL2
			end
			MODE_THREE: begin
				do_pin_next.out = out_latch_reg; // RL3
			end
			MODE_TWO, MODE_TWO_OVF: begin
				// Open-drain: only ever drive low, never pull up
				sda_pin_next.out     = 1'h0; // RL7
				sda_pin_next.oe      = sda_cfg.dir && (!out_latch_reg || !sda_cfg.latch); // RL9
				sda_pin_next.pull_up = 1'h0; // RL13
				scl_pin_next.out     = 1'h0;
				scl_pin_next.oe      = scl_cfg.dir && (!scl_cfg.latch || hold); // RL10
				scl_pin_next.pull_up = 1'h0;
			end
		endcase
	end

	// Registered pin drive; reset leaves every driver off
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			do_pin_reg  <= PIN_RESET; // RL18
			sda_pin_reg <= PIN_RESET;
			scl_pin_reg <= PIN_RESET;
		end else if (ce) begin
			do_pin_reg  <= do_pin_next;
			sda_pin_reg <= sda_pin_next; // RL8
			scl_pin_reg <= scl_pin_next;
		end
	end

	sequence seq_start;
		ce && start_cond;
	endsequence

	sequence seq_wrap;
		ce && scl_edge && count_reg == CNT_MAX;
	endsequence

	chk_off_port_pins: assert property (@(posedge clk) disable iff (!nrst) // RL2
		ce && wire_mode_select == MODE_OFF |=> sda_pin_reg == port_drive($past(sda_cfg))
		&& scl_pin_reg == port_drive($past(scl_cfg))
		&& do_pin_reg == port_drive($past(do_cfg)) && !$rose(start_detect_flag))
		else $error("mode off pins not plain port");
	chk_three_do_data: assert property (@(posedge clk) disable iff (!nrst) // RL3
		ce && wire_mode_select == MODE_THREE |=> do_pin_reg.out == $past(out_latch_reg)
		&& do_pin_reg.oe == $past(do_cfg.dir))
		else $error("three-wire data pin drive wrong");
	chk_three_pullup: assert property (@(posedge clk) disable iff (!nrst) // RL4
		ce && wire_mode_select == MODE_THREE && !do_cfg.dir |=> do_pin_reg.pull_up
		== $past(do_cfg.latch))
		else $error("three-wire pull-up wrong");
	chk_two_open_drain: assert property (@(posedge clk) disable iff (!nrst) // RL7
		ce && two_wire |=> !sda_pin_reg.out && !scl_pin_reg.out && !sda_pin_reg.pull_up
		&& !scl_pin_reg.pull_up)
		else $error("two-wire pins not open-drain");
	chk_sda_pull_low: assert property (@(posedge clk) disable iff (!nrst) // RL9
		ce && two_wire |=> sda_pin_reg.oe == ($past(sda_cfg.dir)
		&& !($past(out_latch_reg) && $past(sda_cfg.latch))))
		else $error("sda drive wrong");
	chk_start_hold: assert property (@(posedge clk) disable iff (!nrst) // RL11
		seq_start ##1 (ce && two_wire && scl_cfg.dir && !start_flag_clear)
		|=> scl_pin_reg.oe)
		else $error("scl not held after start");
	chk_start_clear: assert property (@(posedge clk) disable iff (!nrst) // RL16
		ce && !start_cond |=> start_detect_flag == ($past(start_detect_flag)
		&& !$past(start_flag_clear)))
		else $error("start flag clear wrong");
	chk_ovf_set: assert property (@(posedge clk) disable iff (!nrst) // RL17
		seq_wrap |=> count_overflow_flag && count_reg == CNT_RESET)
		else $error("overflow flag not set on wrap");
	chk_ovf_hold: assert property (@(posedge clk) disable iff (!nrst) // RL14
		ce && wire_mode_select == MODE_TWO_OVF && count_overflow_flag && scl_cfg.dir
		|=> scl_pin_reg.oe)
		else $error("scl not held after overflow");
	chk_ovf_no_hold: assert property (@(posedge clk) disable iff (!nrst) // RL14
		ce && wire_mode_select == MODE_TWO && !start_detect_flag && scl_cfg.latch
		|=> !scl_pin_reg.oe)
		else $error("scl held in plain two-wire");
	chk_two_dir_gate: assert property (@(posedge clk) disable iff (!nrst) // RL8
		ce && two_wire && !sda_cfg.dir && !scl_cfg.dir
		|=> !sda_pin_reg.oe && !scl_pin_reg.oe)
		else $error("two-wire driver on without direction bit");
	chk_start_release: assert property (@(posedge clk) disable iff (!nrst) // RL12
		(ce && start_detect_flag && start_flag_clear && !start_cond)
		##1 (ce && wire_mode_select == MODE_TWO && scl_cfg.latch) |=> !scl_pin_reg.oe)
		else $error("scl still held after start flag clear");
endmodule : serial_wire_mode_output_control

/* File: test/serial_peer_model.sv */
`timescale 1ns/1ps
module serial_peer_model
	import wire_mode_pkg::*;
(
	// Device drive of the shared lines
	input  wire pin_drive_s sda_pin,
	input  wire pin_drive_s scl_pin,
	// Resolved line levels
	output logic            sda_wire,
	output logic            scl_wire
);
	logic sda_drv;
	logic scl_drv;

	// Clock stands high between frames, like an idle bus
	initial begin
		sda_drv = 1'b1;
		scl_drv = 1'b1;
	end

	// Pulled-up lines: anyone driving low wins, so no stale level survives
	assign sda_wire = sda_drv & ~(sda_pin.oe & ~sda_pin.out);
	assign scl_wire = scl_drv & ~(scl_pin.oe & ~scl_pin.out);

	// First half of a 64 ns bit: data set up, clock low
	task automatic fall(input logic b);
		sda_drv = b;
		scl_drv = 1'b0;
		#32;
	endtask : fall

	// Second half: rising clock samples the data
	task automatic rise();
		scl_drv = 1'b1;
		#32;
	endtask : rise
endmodule : serial_peer_model

/* File: test/serial_wire_mode_output_control_tb.sv */
`timescale 1ns/1ps
module serial_wire_mode_output_control_tb
	import wire_mode_pkg::*;
();
	logic       clk, nrst, ce, sclr, oclr, tx_valid, tx_ready, rx_strobe_reg, sflag, oflag;
	logic       sin, sck;
	logic [1:0] mode;
	logic [7:0] tx_data, rx_data_reg, last_rx;
	logic [3:0] count_reg;
	port_cfg_s  do_cfg, sda_cfg, scl_cfg;
	pin_drive_s do_p, sda_p, scl_p;
	int         num_errors, n_compared, n_rx, n;

	serial_wire_mode_output_control uut (.clk(clk), .nrst(nrst), .ce(ce),
		.wire_mode_select(mode), .do_cfg(do_cfg), .sda_cfg(sda_cfg), .scl_cfg(scl_cfg),
		.start_flag_clear(sclr), .ovf_flag_clear(oclr), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .rx_data_reg(rx_data_reg),
		.rx_strobe_reg(rx_strobe_reg), .start_detect_flag(sflag),
		.count_overflow_flag(oflag), .count_reg(count_reg), .serial_in_pin(sin),
		.serial_clock_pin(sck), .do_pin_reg(do_p), .sda_pin_reg(sda_p), .scl_pin_reg(scl_p));
	serial_peer_model peer (.sda_pin(sda_p), .scl_pin(scl_p), .sda_wire(sin), .scl_wire(sck));

	// Clock generation
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Catch received bytes, the strobe is too short to poll from tasks
	always @(posedge clk) begin
		if (rx_strobe_reg) begin
			last_rx <= rx_data_reg;
			n_rx++;
		end
	end

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : tick

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	// One byte clocked by the peer, MSB first; optional check of the data out pin
	task automatic xfer(input logic [7:0] d, input logic chk, input logic msb);
		int k;
		k = n_rx;
		for (int i = 7; i >= 0; i--) begin
			peer.fall(d[i]);
			if (chk && i == 7) begin
				tick(2);
				cmp(8'(do_p), {5'h0, msb, 2'b10});
			end
			peer.rise();
		end
		tick(6);
		cmp(8'(n_rx - k), 8'h1);
		cmp(last_rx, d);
		cmp({4'h0, count_reg}, 8'h0);
		cmp({7'h0, oflag}, 8'h1);
	endtask : xfer

	// Port-style drive of one pin from its latch and direction
	function automatic logic [7:0] port_exp(input port_cfg_s c);
		return {5'h0, c.latch, c.dir, ~c.dir & c.latch};
	endfunction : port_exp

	// Hang guard, far beyond the expected run
	initial begin
		#300000;
		num_errors++;
		summarize();
	end

	initial begin
		{nrst, sclr, oclr, tx_valid, tx_data, mode, n_rx, n} = '0;
		{num_errors, n_compared, last_rx} = '0;
		ce = 1'b1;
		do_cfg = 2'b10;
		sda_cfg = 2'b10;
		scl_cfg = 2'b10;
		tick(1);
		cmp({tx_ready, oflag, sflag, 3'h0, count_reg[1:0]}, 8'h0);
		cmp(8'({do_p, sda_p}), 8'h0);
		tick(1);
		nrst = 1'b1;
		tick(2);
		cmp({7'h0, tx_ready}, 8'h1);
		cmp(8'(do_p), 8'h5);
		$display("test reset done");

		// Inputs still clock the shifter and counter with outputs off
		xfer(8'h96, 1'b0, 1'b0);
		oclr = 1'b1;
		tick(1);
		oclr = 1'b0;
		tick(2);
		cmp({7'h0, oflag}, 8'h0);
		$display("test mode zero input done");

		// Three-wire transmit: MSB reaches the data pin
		mode = MODE_THREE;
		do_cfg = 2'b01;
		tx_valid = 1'b1;
		tx_data = 8'hA5;
		tick(1);
		tx_valid = 1'b0;
		tick(4);
		xfer(8'h3C, 1'b1, 1'b1);
		$display("test three-wire byte done");

		// Fill the buffer until refused, then drain it in order
		while (tx_ready === 1'b1 && n < 24) begin
			tx_valid = 1'b1;
			tx_data = {n[0], n[6:0]};
			tick(1);
			n++;
		end
		tx_valid = 1'b0;
		cmp({7'h0, n >= 17 && n < 24}, 8'h1);
		for (int i = 0; i < n; i++)
			xfer(8'h5A ^ 8'(i), 1'b1, i[0]);
		cmp({7'h0, tx_ready}, 8'h1);
		$display("test buffer fill and drain done");

		// Pin drive tables for all modes, flags held clear meanwhile
		sclr = 1'b1;
		oclr = 1'b1;
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 4; k++) begin
				mode = 2'(m);
				{do_cfg, sda_cfg, scl_cfg} = {3{2'(k)}};
				tick(8);
				if (m == 1) begin
					cmp(8'(do_p) & 8'h3, port_exp(do_cfg) & 8'h3);
					cmp(8'(sda_p), port_exp(sda_cfg));
					cmp(8'(scl_p), port_exp(scl_cfg));
				end else if (m == 0) begin
					cmp(8'(do_p), port_exp(do_cfg));
					cmp(8'(sda_p), port_exp(sda_cfg));
					cmp(8'(scl_p), port_exp(scl_cfg));
				end else begin
					cmp(8'(do_p), port_exp(do_cfg));
					cmp(8'(scl_p), {6'h0, scl_cfg.dir & ~scl_cfg.latch, 1'b0});
					if (!sda_cfg.latch)
						cmp(8'(sda_p), {6'h0, sda_cfg.dir, 1'b0});
				end
			end
		end
		$display("test pin tables done");

		// Table glitches are whole low pulses, so the count is even; pair edges home
		mode = MODE_OFF;
		sda_cfg = 2'b10;
		scl_cfg = 2'b11;
		tick(8);
		for (int j = 0; j < 8 && count_reg != 4'h0; j++) begin
			peer.fall(1'b1);
			peer.rise();
		end
		cmp({4'h0, count_reg}, 8'h0);

		// Overflow hold only in mode three
		{sclr, oclr} = 2'b00;
		mode = MODE_TWO_OVF;
		sda_cfg = 2'b10;
		scl_cfg = 2'b11;
		for (int i = 0; i < 16; i++)
			xfer_bit: begin
				peer.fall(1'b1);
				peer.rise();
			end
		tick(4);
		cmp({7'h0, oflag}, 8'h1);
		cmp(8'(scl_p), 8'h2);
		mode = MODE_TWO;
		tick(4);
		cmp(8'(scl_p), 8'h0);
		mode = MODE_TWO_OVF;
		oclr = 1'b1;
		tick(1);
		oclr = 1'b0;
		tick(4);
		cmp({6'h0, oflag, scl_p.oe}, 8'h0);
		$display("test overflow hold done");

		// Start condition: ignored in mode zero, held until cleared in two-wire
		mode = MODE_OFF;
		peer.sda_drv = 1'b0;
		tick(6);
		cmp({7'h0, sflag}, 8'h0);
		peer.sda_drv = 1'b1;
		mode = MODE_TWO;
		tick(6);
		peer.sda_drv = 1'b0;
		tick(6);
		cmp({6'h0, sflag, scl_p.oe}, 8'h3);
		tick(10);
		cmp({6'h0, sflag, scl_p.oe}, 8'h3);
		sclr = 1'b1;
		tick(1);
		sclr = 1'b0;
		tick(4);
		cmp({6'h0, sflag, scl_p.oe}, 8'h0);
		$display("test start hold done");
		summarize();
	end
endmodule : serial_wire_mode_output_control_tb
